// ---- dv/audio_link_partner.sv ----
// far-side audio/serial device: link clock source and bit catcher
// assumes the block shifts on the rising edge of the clock it is given
`timescale 1ns/1ps
`default_nettype none
module audio_link_partner (
   output logic link_clk,
   input wire logic sdo,
   input wire logic fsync,
   output logic [31:0] rx_word,
   output logic [7:0] rx_count
);
   // ==========================================
   // link clock, 6 ns, phase unrelated to the bus clock
   // runs free: the block needs it to see its own reset and requests
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   // ==========================================
   // frame catcher: bits gathered while sync is high, msb first
   // only frames that hold sync for the whole frame are caught whole
   logic [31:0] shift_in; // frame in progress
   logic [7:0] nbits_in; // bits caught so far
   logic fs_prev; // sync seen at the previous edge
   initial begin
      shift_in = '0;
      nbits_in = '0;
      fs_prev = 1'b0;
      rx_word = '0;
      rx_count = '0;
   end
   // sample on the launching edge, so the value seen is the previous edge's
   always @(posedge link_clk) begin
      fs_prev <= (fsync === 1'b1);
      if (fsync === 1'b1) begin
         shift_in <= {shift_in[30:0], sdo};
         nbits_in <= nbits_in + 8'h01;
      end else if (fs_prev) begin
         // sync fell: hand the frame over, start afresh
         rx_word <= shift_in;
         rx_count <= nbits_in;
         shift_in <= '0;
         nbits_in <= '0;
      end
   end
endmodule : audio_link_partner
`default_nettype wire

// ---- dv/spi_audio_core_tb.sv ----
// self-checking bench: registers over ahb-lite, audio config, transmit check
// assumes the core answers with zero wait states and busy reads in STATUS bit 7
`timescale 1ns/1ps
`default_nettype none
`include "spi_audio_cfg.svh"
module spi_audio_core_tb;
   import spi_audio_pkg::*;
   // ==========================================
   // signals
   logic clk = 1'b0, resetn = 1'b0, link_clk; // clocks and reset
   logic hsel = 1'b0, hwrite = 1'b0, hready; // bus control
   logic [31:0] haddr = '0, hwdata = '0, hrdata; // bus data
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010; // word only
   logic hreadyout, hresp, sdo, fs, idle_lvl, active;
   int mismatches = 0, checks_done = 0, cycles = 0, seed = 71;
   logic [15:0] acfg_m = '0, crc_m; // models of register contents
   logic spi_on = 1'b0;
   logic [31:0] rx_word; // last frame caught by the partner
   logic [7:0] rx_count; // its length in bits
   logic [31:0] rv, v;
   assign hready = hreadyout;
   always #20 clk = ~clk;
   spi_audio_core i_spi_audio_core (.clk(clk), .resetn(resetn), .link_clk(link_clk),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .serial_data_out(sdo), .frame_sync_out(fs),
      .sclk_idle_level(idle_lvl), .audio_active(active));
   audio_link_partner i_audio_link_partner (.link_clk(link_clk), .sdo(sdo), .fsync(fs),
      .rx_word(rx_word), .rx_count(rx_count));
   // ==========================================
   // tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one single transfer, waits on hready in both phases
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1; haddr <= {24'h0000_00, a}; htrans <= 2'b10; hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask : bus
   // write audio config through the model, read back, compare outputs
   task automatic acfg_wr(input logic [15:0] d);
      logic [15:0] n;
      n = d & `ACFG_WMASK;
      if (acfg_m[`ACFG_EN] && acfg_m[`ACFG_PERS]) n = (n & ~`ACFG_LOCK) | (acfg_m & `ACFG_LOCK);
      if (spi_on || acfg_m[`ACFG_EN]) n[`ACFG_PERS] = acfg_m[`ACFG_PERS];
      acfg_m = n;
      bus(`OFS_ACFG, 1'b1, {16'h0000, d}, rv);
      bus(`OFS_ACFG, 1'b0, 32'h0000_0000, rv);
      chk("acfg", rv, {16'h0000, acfg_m});
      chk("active", {31'h0, active}, {31'h0, acfg_m[11] & acfg_m[10]});
      chk("idle", {31'h0, idle_lvl}, {31'h0, acfg_m[11] & acfg_m[10] & acfg_m[3]});
   endtask : acfg_wr
   // one spi or audio frame, then the check value after busy drops
   task automatic frame(input logic [15:0] d, input int nb, input logic fold);
      int k;
      bus(`OFS_DATA, 1'b1, {16'h0000, d}, rv);
      // long frames leave room for a refused second write while busy
      if (nb == 32) bus(`OFS_DATA, 1'b1, {16'h0000, ~d}, rv);
      bus(`OFS_STAT, 1'b0, 32'h0000_0000, rv);
      chk("busy", {31'h0, rv[`STAT_BUSY]}, 32'h0000_0001);
      // software waits for idle before trusting the check value
      for (k = 0; k < 200 && rv[`STAT_BUSY] !== 1'b0; k++) begin
         bus(`OFS_STAT, 1'b0, 32'h0000_0000, rv);
      end
      chk("idle after frame", {31'h0, rv[`STAT_BUSY]}, 32'h0000_0000);
      chk("link bits", {24'h0000_00, rx_count}, nb);
      chk("link word", rx_word, nb == 8 ? {24'h0000_00, d[7:0]} :
          nb == 16 ? {16'h0000, d} : {d, 16'h0000});
      // plain msb-first crc with the reset polynomial, spi frames only
      if (fold) crc_m = crc_m ^ (nb == 8 ? {8'h00, d[7:0]} : d);
      for (k = 0; fold && k < nb; k++) begin
         if (nb == 8) crc_m = crc_m[7] ? {8'h00, crc_m[6:0], 1'b0} ^ 16'h0007
                                       : {8'h00, crc_m[6:0], 1'b0};
         else crc_m = crc_m[15] ? {crc_m[14:0], 1'b0} ^ 16'h0007 : {crc_m[14:0], 1'b0};
      end
      bus(`OFS_TXCHK, 1'b0, 32'h0000_0000, rv);
      chk("tx_check", rv, {16'h0000, crc_m});
   endtask : frame
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   // ==========================================
   // timeout at 20000 cycles, far above the few hundred cycles the test takes
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      bus(`OFS_TXCHK, 1'b0, 32'h0000_0000, rv);
      chk("tx_check reset", rv, 32'h0000_0000);
      bus(`OFS_ACFG, 1'b0, 32'h0000_0000, rv);
      chk("acfg reset", rv, 32'h0000_0000);
      bus(`OFS_POLY, 1'b0, 32'h0000_0000, rv);
      chk("poly reset", rv, 32'h0000_0007);
      bus(`OFS_TXCHK, 1'b1, 32'h0000_FFFF, rv);
      bus(`OFS_TXCHK, 1'b0, 32'h0000_0000, rv);
      chk("tx_check read-only", rv, 32'h0000_0000);
      bus(8'h14, 1'b1, 32'h0000_FFFF, rv);
      bus(8'h14, 1'b0, 32'h0000_0000, rv);
      chk("unmapped", rv, 32'h0000_0000);
      $display("test reset and map done");
      // enable bit set under spi personality does nothing
      acfg_wr(16'h0400);
      acfg_wr(16'h0000);
      $display("test spi personality done");
      repeat (4) begin
         v = $random(seed);
         if (v[2:1] == 2'b11) v[2] = 1'b0;
         acfg_wr((v[15:0] | 16'h0800) & 16'hFBFF);
         acfg_wr((v[15:0] | 16'h0C00));
         v = $random(seed);
         acfg_wr(v[15:0] | 16'h0400);
         acfg_wr(16'h0800);
         acfg_wr(16'h0000);
      end
      $display("test audio config done");
      spi_on = 1'b1;
      bus(`OFS_CTRL, 1'b1, 32'h0000_0001, rv);
      acfg_wr(16'h0800);
      bus(`OFS_CTRL, 1'b1, 32'h0000_0005, rv);
      crc_m = 16'h0000;
      bus(`OFS_TXCHK, 1'b0, 32'h0000_0000, rv);
      chk("clear 8", rv, 32'h0000_0000);
      repeat (3) begin
         v = $random(seed);
         frame({8'h00, v[7:0]}, 8, 1'b1);
      end
      bus(`OFS_CTRL, 1'b1, 32'h0000_0003, rv);
      bus(`OFS_CTRL, 1'b1, 32'h0000_0007, rv);
      crc_m = 16'h0000;
      bus(`OFS_TXCHK, 1'b0, 32'h0000_0000, rv);
      chk("clear 16", rv, 32'h0000_0000);
      repeat (2) begin
         v = $random(seed);
         frame(v[15:0], 16, 1'b1);
      end
      $display("test transmit check done");
      bus(`OFS_CTRL, 1'b1, 32'h0000_0000, rv);
      spi_on = 1'b0;
      // 24-bit samples force 32-bit channels; left-justified master send
      acfg_wr(16'h0A1A);
      acfg_wr(16'h0E1A);
      v = $random(seed);
      frame(v[15:0] ^ 16'hA5C3, 32, 1'b0);
      $display("test audio frame done");
      close_out();
   end
endmodule : spi_audio_core_tb
`default_nettype wire

// ---- hdl/link_shifter.sv ----
// link-domain frame shifter: data out msb first, frame sync
// assumes cmd held stable by the bus domain while a request is open
`timescale 1ns/1ps
`default_nettype none
`include "spi_audio_cfg.svh"
module link_shifter
   import spi_audio_pkg::*;
(
   input wire logic link_clk,
   input wire logic link_rstn,
   input wire logic req_sync,
   input var link_cmd_s cmd,
   output logic sdo,
   output logic fsync,
   output logic ack_tog
);
   shift_state_e state; // shifter state
   logic [31:0] word; // shifting word
   logic [5:0] cnt; // bit index
   wire start = (state == ST_IDLE) && (req_sync != ack_tog);
   wire last = cnt == cmd.nbits - 6'd1;
   wire fs_pcm = cmd.fs_long ? (cnt < `FS_LONG_BITS) : (cnt == 6'd0);
   wire fs_now = cmd.drive_fs & (cmd.pcm ? fs_pcm : 1'b1);
   // ==========================================
   // shifter, toggles ack when frame done
   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         state <= ST_IDLE;
         word <= `RST_ZERO32;
         cnt <= 6'd0;
         sdo <= 1'b0;
         fsync <= 1'b0;
         ack_tog <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  word <= cmd.word;
                  cnt <= 6'd0;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               sdo <= cmd.tx & word[31];
               fsync <= fs_now;
               word <= {word[30:0], 1'b0};
               cnt <= cnt + 6'd1;
               if (last) state <= ST_ACK;
            end
            ST_ACK: begin
               sdo <= 1'b0;
               fsync <= 1'b0;
               ack_tog <= ~ack_tog;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   a_fsync_short: assert property (@(posedge link_clk) disable iff (!link_rstn)
      state == ST_SHIFT && cmd.pcm && !cmd.fs_long && cnt != 6'd0 |=> !fsync)
      else $error("short frame sync held past first bit");
endmodule : link_shifter
`default_nettype wire

// ---- hdl/spi_audio_core.sv ----
// audio/serial configuration and transmit check block, ahb-lite slave
// assumes one ahb-lite master, link clock from the far party on link_clk
// ==========================================
// Overview of operation
// - crc8 or crc16 over sent spi frames
// - enabling check clears check value
// - bit 0 picks 16/32-bit channel
// - too-short channel widened by hardware
// - bits 2:1 pick sample width
// - bit 3 sets idle clock level
// - bits 5:4 pick audio standard
// - bit 7 sync length, pcm only
// - bits 9:8 role and direction
// - bit 10 enables audio function
// - bit 11 personality, change when spi and audio both disabled
// - spi personality ignores audio fields
// - hardware busy flag during transfer
`timescale 1ns/1ps
`default_nettype none
`include "spi_audio_cfg.svh"
module spi_audio_core
   import spi_audio_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic serial_data_out,
   output logic frame_sync_out,
   output logic sclk_idle_level,
   output logic audio_active
);
   // ==========================================
   // register state
   logic [2:0] ctrl; // spi enable, frame16, check enable
   logic [15:0] data_reg; // frame to send
   logic [15:0] poly; // check polynomial
   logic [15:0] tx_check_value; // transmit check result
   logic [15:0] audio_config_reg; // audio configuration
   logic req_tog; // request toggle to link
   ahb_aphase_s aph; // latched address phase
   // ==========================================
   // crossings
   logic ack_sync; // ack toggle in bus domain
   logic req_sync; // req toggle in link domain
   logic link_rstn; // reset in link domain
   link_cmd_s cmd; // frame descriptor
   // ==========================================
   // field views
   wire chk_en = ctrl[`CTL_CHK_EN];
   wire frame16 = ctrl[`CTL_FRAME16];
   wire spi_en = ctrl[`CTL_SPI_EN];
   wire channel_width_sel = audio_config_reg[`ACFG_CHANNEL_WIDTH_SEL];
   wire [1:0] dlen = audio_config_reg[`ACFG_DLEN];
   wire [1:0] std = audio_config_reg[`ACFG_STD];
   wire fs_long = audio_config_reg[`ACFG_FSYNC];
   wire [1:0] role = audio_config_reg[`ACFG_ROLE];
   wire aud_en = audio_config_reg[`ACFG_EN];
   wire pers = audio_config_reg[`ACFG_PERS];
   // ==========================================
   // personality and enables
   // spi ignores audio fields
   wire aud_on = pers & aud_en;
   wire spi_on = ~pers & spi_en;
   wire busy = req_tog ^ ack_sync;
   // ==========================================
   // audio frame shaping
   // widen short channel
   wire ch32 = channel_width_sel | (dlen != 2'b00);
   wire [5:0] aud_bits = ch32 ? `NB_32 : `NB_16;
   wire [15:0] pad16 = `RST_ZERO16;
   wire [31:0] w_rj = ch32 ? {pad16, data_reg} : {data_reg, pad16};
   wire [31:0] w_i2s = {1'b0, data_reg, pad16[14:0]};
   wire [31:0] w_lj = {data_reg, pad16};
   wire [31:0] aud_word = (std == `STD_RJ) ? w_rj : (std == `STD_I2S) ? w_i2s : w_lj;
   // spi frames of 8 or 16 bits
   wire [31:0] spi_word = frame16 ? {data_reg, pad16} : {data_reg[7:0], pad16, 8'h00};
   wire [5:0] spi_bits = frame16 ? `NB_16 : `NB_8;
   // role picks tx and sync drive
   wire role_tx = ~role[0];
   wire role_master = role[1];
   wire is_pcm = std == `STD_PCM;
   // ==========================================
   // frame descriptor to link side
   assign cmd.word = aud_on ? aud_word : spi_word;
   assign cmd.nbits = aud_on ? aud_bits : spi_bits;
   assign cmd.pcm = aud_on & is_pcm;
   assign cmd.fs_long = fs_long;
   assign cmd.tx = aud_on ? role_tx : 1'b1;
   assign cmd.drive_fs = aud_on ? role_master : 1'b1;
   // ==========================================
   // ahb-lite decode
   wire take = hsel & htrans[1] & hready;
   wire [7:0] ra = haddr[7:0];
   wire wr = aph.valid & aph.write;
   wire wr_ctrl = wr & (aph.addr == `OFS_CTRL);
   wire wr_data = wr & (aph.addr == `OFS_DATA);
   wire wr_poly = wr & (aph.addr == `OFS_POLY);
   wire wr_acfg = wr & (aph.addr == `OFS_ACFG);
   // a frame is sent only when a function is on and idle
   wire send = wr_data & (spi_on | aud_on) & ~busy;
   wire chk_clr = wr_ctrl & hwdata[`CTL_CHK_EN] & ~chk_en;
   // ==========================================
   // audio config write masking
   // locked while enabled
   wire [15:0] lock_m = aud_on ? `ACFG_LOCK : `RST_ZERO16;
   wire pers_ok = ~spi_en & ~aud_en;
   wire [15:0] pers_m = pers_ok ? `RST_ZERO16 : (16'h0001 << `ACFG_PERS);
   wire [15:0] keep_m = lock_m | pers_m | ~`ACFG_WMASK;
   wire [15:0] next_acfg = (audio_config_reg & keep_m) | (hwdata[15:0] & ~keep_m);
   // ==========================================
   // read mux
   wire [15:0] stat = {8'h00, busy, 7'h00};
   wire [15:0] rd16 = (ra == `OFS_CTRL) ? {13'h0000, ctrl} :
                      (ra == `OFS_STAT) ? stat :
                      (ra == `OFS_DATA) ? data_reg :
                      (ra == `OFS_POLY) ? poly :
                      (ra == `OFS_TXCHK) ? tx_check_value :
                      (ra == `OFS_ACFG) ? audio_config_reg : `RST_ZERO16;
   // ==========================================
   // check step over one frame, msb first
   function automatic logic [15:0] chk_step(input logic [15:0] c, input logic [15:0] d,
                                            input logic [15:0] p, input logic wide);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         if (wide || i < 8) begin
            fb = (wide ? r[15] : r[7]) ^ d[i];
            r = wide ? {r[14:0], 1'b0} : {8'h00, r[6:0], 1'b0};
            if (fb) r = r ^ (wide ? p : {8'h00, p[7:0]});
         end
      end
      return r;
   endfunction : chk_step
   wire [15:0] next_chk = chk_step(tx_check_value, data_reg, poly, frame16);
   // ==========================================
   // address phase latch
   always_ff @(posedge clk) begin
      if (!resetn) aph <= '0;
      else if (hready) aph <= {take, hwrite, haddr[7:0]};
   end
   // ==========================================
   // read data and response, zero wait
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hrdata <= `RST_ZERO32;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (take && !hwrite) begin
         hrdata <= {pad16, rd16};
      end
   end
   // ==========================================
   // control, poly and data registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl <= 3'b000;
         poly <= `RST_POLY;
         data_reg <= `RST_ZERO16;
      end else begin
         if (wr_ctrl) ctrl <= hwdata[2:0];
         if (wr_poly) poly <= hwdata[15:0];
         if (send) data_reg <= hwdata[15:0];
      end
   end
   // ==========================================
   // audio configuration register
   always_ff @(posedge clk) begin
      if (!resetn) audio_config_reg <= `RST_ZERO16;
      else if (wr_acfg) audio_config_reg <= next_acfg;
   end
   // ==========================================
   // transmit check register, spi frames only
   // note: check runs one cycle after send, on the data just stored
   logic chk_pend; // frame waiting for check step
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_check_value <= `RST_ZERO16;
         chk_pend <= 1'b0;
      end else if (chk_clr) begin
         tx_check_value <= `RST_ZERO16;
         chk_pend <= 1'b0;
      end else begin
         chk_pend <= send & spi_on & chk_en;
         if (chk_pend) tx_check_value <= next_chk;
      end
   end
   // ==========================================
   // request toggle, held data makes word stable for link side
   // busy set by hardware
   always_ff @(posedge clk) begin
      if (!resetn) req_tog <= 1'b0;
      else if (send) req_tog <= ~req_tog;
   end
   // ==========================================
   // visible audio state
   // idle clock level out
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sclk_idle_level <= 1'b0;
         audio_active <= 1'b0;
      end else begin
         sclk_idle_level <= aud_on & audio_config_reg[`ACFG_IDLE];
         audio_active <= aud_on;
      end
   end
   // ==========================================
   // crossings; data word is quasi-static while busy
   logic link_ack; // ack toggle from link side
   sync2 #(.W(1)) u_ack (.clk(clk), .din(link_ack), .dout(ack_sync));
   sync2 #(.W(2)) u_req (.clk(link_clk), .din({req_tog, resetn}),
                         .dout({req_sync, link_rstn}));
   link_shifter u_shift (
      .link_clk(link_clk),
      .link_rstn(link_rstn),
      .req_sync(req_sync),
      .cmd(cmd),
      .sdo(serial_data_out),
      .fsync(frame_sync_out),
      .ack_tog(link_ack)
   );
   // ==========================================
   // checks in the bus domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_enable_check;
      wr_ctrl && hwdata[`CTL_CHK_EN] && !chk_en;
   endsequence
   a_check_clear: assert property (s_enable_check |=> tx_check_value == `RST_ZERO16)
      else $error("check value not cleared on enable");
   a_check_narrow: assert property (!frame16 && !chk_clr
      && tx_check_value[15:8] == 8'h00 |=> tx_check_value[15:8] == 8'h00)
      else $error("8-bit check grew upper byte");
   a_busy_rise: assert property (send |=> busy[*2])
      else $error("busy not raised after send");
   a_busy_block: assert property (busy && wr_data |=> $stable(req_tog))
      else $error("second frame sent while busy");
   a_chan_widen: assert property (aud_on && dlen != 2'b00 |-> cmd.nbits == `NB_32)
      else $error("channel width not widened");
   a_spi_ignore: assert property (!pers |=> !audio_active && !sclk_idle_level)
      else $error("audio state shown in spi personality");
   a_lock_hold: assert property (aud_on && wr_acfg |=>
      (audio_config_reg & `ACFG_LOCK) == ($past(audio_config_reg) & `ACFG_LOCK))
      else $error("locked field changed while enabled");
   a_pers_hold: assert property (wr_acfg && (spi_en || aud_en) |=> $stable(pers))
      else $error("personality changed while a function is on");
   a_idle_level: assert property (aud_on |=>
      sclk_idle_level == $past(audio_config_reg[`ACFG_IDLE]))
      else $error("idle level does not follow config");
   a_pcm_sync: assert property (aud_on && !is_pcm |-> !cmd.pcm)
      else $error("pcm sync applied outside pcm");
endmodule : spi_audio_core
`default_nettype wire

// ---- hdl/sync2.sv ----
// two-flop synchroniser, one per bit
// assumes inputs are levels stable for more than two destination edges
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // ==========================================
   // per-bit stages
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         // first stage feeds only the second
         logic meta;
         always_ff @(posedge clk) begin
            meta <= din[g];
            dout[g] <= meta;
         end
      end
   endgenerate
endmodule : sync2
`default_nettype wire

// ---- inc/spi_audio_cfg.svh ----
// offsets, field positions, reset values and counts of the audio/serial block
// assumes inclusion by bare name from the package and from design modules
`ifndef SPI_AUDIO_CFG_SVH
`define SPI_AUDIO_CFG_SVH
// ==========================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h08
`define OFS_DATA 8'h0C
`define OFS_POLY 8'h10
`define OFS_TXCHK 8'h18
`define OFS_ACFG 8'h1C
// ==========================================
// reset values
`define RST_POLY 16'h0007
`define RST_ZERO16 16'h0000
`define RST_ZERO32 32'h0000_0000
// ==========================================
// control and status fields
`define CTL_SPI_EN 0
`define CTL_FRAME16 1
`define CTL_CHK_EN 2
`define STAT_BUSY 7
// ==========================================
// audio configuration fields
`define ACFG_CHANNEL_WIDTH_SEL 0
`define ACFG_DLEN 2:1
`define ACFG_IDLE 3
`define ACFG_STD 5:4
`define ACFG_FSYNC 7
`define ACFG_ROLE 9:8
`define ACFG_EN 10
`define ACFG_PERS 11
`define ACFG_WMASK 16'h0FBF
`define ACFG_LOCK 16'h03BF
// ==========================================
// codes and counts
`define STD_I2S 2'b00
`define STD_RJ 2'b10
`define STD_PCM 2'b11
`define NB_8 6'd8
`define NB_16 6'd16
`define NB_32 6'd32
`define FS_LONG_BITS 6'd13
`endif

// ---- inc/spi_audio_pkg.sv ----
// types shared by the audio/serial block and its link shifter
// assumes the cfg header sits on the include path
`include "spi_audio_cfg.svh"
package spi_audio_pkg;
   // ==========================================
   // link shifter state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_ACK = 3'b100
   } shift_state_e;
   // ==========================================
   // one frame handed to the link domain
   typedef struct packed {
      logic [31:0] word; // msb first
      logic [5:0] nbits; // bits in frame
      logic pcm; // pcm framing
      logic fs_long; // long sync
      logic tx; // drive data
      logic drive_fs; // drive sync
   } link_cmd_s;
   // ==========================================
   // latched address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ahb_aphase_s;
endpackage : spi_audio_pkg
